/* File: shared/ext_irq_pkg.sv */
// Constants, register map and sense encodings for the external pin interrupt unit
package ext_irq_pkg;

    // Register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] OFS_EXT_ENABLE_MASK  = 8'h3D;
    localparam logic [7:0] OFS_PC_GROUP_CONTROL = 8'h68;
    localparam logic [7:0] OFS_PC_MASK_ZERO     = 8'h6B;
    localparam logic [7:0] OFS_PC_MASK_ONE      = 8'h6C;
    localparam logic [7:0] OFS_PC_MASK_TWO      = 8'h6D;
    localparam logic [7:0] OFS_EXT_SENSE_CTRL   = 8'h70;
    localparam logic [7:0] OFS_EXT_FLAGS        = 8'h71;
    localparam logic [7:0] OFS_PC_FLAGS         = 8'h72;

    // Reset values
    localparam logic [7:0] RST_REG_ZERO = 8'h00;

    // Field positions
    localparam int SENSE_ZERO_POS = 0;
    localparam int SENSE_ONE_POS  = 2;
    localparam int PC_GROUP_W     = 8;
    localparam int PC_ONE_USED    = 7;

    // Pin sampling depth
    localparam int SYNC_STAGES = 3;

    // Sense field encodings
    typedef enum logic [1:0] {
        SENSE_LOW  = 2'h0,
        SENSE_ANY  = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_mode_t;

endpackage

/* File: hdl/pin_sync.sv */
// Three-stage pin sampler with agreement filter and change pulse
`timescale 1ns/1ps
module pin_sync
    import ext_irq_pkg::*;
#(
    parameter int W = 1
)
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rstn,
    // Raw pins
    input  wire logic [W-1:0] pin_raw,
    // Filtered level and one-cycle change pulse
    output logic      [W-1:0] level,
    output logic      [W-1:0] toggled
);

    logic [W-1:0] latch_ff;
    logic [W-1:0] sync_a_ff;
    logic [W-1:0] sync_b_ff;
    logic [W-1:0] level_ff;
    logic [W-1:0] toggled_ff;
    logic [2:0]   fill_ff;
    logic [W-1:0] nxt_level;

    // Edges after reset until the chain holds real pin values, plus one to load the level
    localparam logic [2:0] FILL_DONE = 3'(SYNC_STAGES + 1);

    // Latch stage feeds only the next stage
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            latch_ff  <= '0;
            sync_a_ff <= '0;
            sync_b_ff <= '0;
        end
        else
        begin
            latch_ff  <= pin_raw;
            sync_a_ff <= latch_ff;
            sync_b_ff <= sync_a_ff;
        end
    end

    // Accept a new level only once the last two stages agree
    always_comb
    begin
        for (int i = 0; i < W; i++)
            nxt_level[i] = (sync_a_ff[i] == sync_b_ff[i]) ? sync_b_ff[i] : level_ff[i];
    end

    // First settled sample after reset loads without a change pulse,
    // so a pin idling high does not look like an edge after reset
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            level_ff   <= '0;
            toggled_ff <= '0;
            fill_ff    <= 3'h0;
        end
        else
        begin
            level_ff   <= nxt_level;
            toggled_ff <= (fill_ff == FILL_DONE) ? (nxt_level ^ level_ff) : '0;
            if (fill_ff != FILL_DONE)
                fill_ff <= fill_ff + 3'h1;
        end
    end

    assign level   = level_ff;
    assign toggled = toggled_ff;

endmodule

/* File: hdl/edge_sense.sv */
// Sense-mode decoder for one dedicated interrupt pin
`timescale 1ns/1ps
module edge_sense
    import ext_irq_pkg::*;
(
    // Mode and sampled pin
    input  wire logic [1:0] sense,
    input  wire logic       level,
    input  wire logic       toggled,
    // I/O clock running
    input  wire logic       run,
    // Edge trigger pulse
    output logic            trig
);

    // edges need running clock
    // Edges count only while the I/O clock runs
    always_comb
    begin
        unique case (sense_mode_t'(sense))
            SENSE_LOW:  trig = 1'b0;
            SENSE_ANY:  trig = run & toggled;
            SENSE_FALL: trig = run & toggled & ~level;
            SENSE_RISE: trig = run & toggled & level;
        endcase
    end

endmodule

/* File: hdl/external_pin_interrupt_unit.sv */
// External pin interrupt unit: dedicated pins, pin-change groups, registers
// What this block does
// - Group 2/1/0 requests from inputs 23..16/14..8/7..0
// - Pins trigger even when driven as outputs
// - Pin-change detection runs without the I/O clock
// - Level mode requests while pin stays low
// - Edge detection needs running I/O clock
// - Low level detected without the I/O clock
// - Short level on wake-up gives no request
// - Pin one sense at bits 3:2
// - Pin zero sense at bits 1:0
// - Pins sampled; pulses over two clocks detected
// - Pin enables gated by global enable
// - Pin flag set on edge, cleared by handler/one
// - Pin flag reads zero in level mode
// - Group enables gated by global enable
// - Per-group masks pick contributing inputs
// - Unused register bits read as zero
// - Group flag set on change, cleared by handler/one
// - Mask bit with group enable enables input
`timescale 1ns/1ps
module external_pin_interrupt_unit
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rstn,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // Core status
    input  wire logic              global_irq_enable,
    input  wire logic              io_clk_run,
    input  wire logic [4:0]        irq_taken,
    // Pins
    input  wire logic              ext_irq_pin_zero,
    input  wire logic              ext_irq_pin_one,
    input  wire logic [23:0]       pin_change_inputs,
    // Requests
    output logic                   ext_req_zero,
    output logic                   ext_req_one,
    output logic                   pc_group_zero_request,
    output logic                   pc_group_one_request,
    output logic                   pc_group_two_request,
    output logic                   wake_request
);

    // Software-visible state
    logic [1:0]  ext_enable_ff;
    logic [2:0]  pc_enable_ff;
    logic [3:0]  sense_ctl_ff;
    logic [7:0]  pc_mask_zero_ff;
    logic [6:0]  pc_mask_one_ff;
    logic [7:0]  pc_mask_two_ff;
    logic [1:0]  ext_flag_ff;
    logic [2:0]  pc_flag_ff;
    logic [DATA_W-1:0] rdata_ff;

    // Request outputs
    logic [1:0]  ext_req_ff;
    logic [2:0]  pc_req_ff;
    logic        wake_ff;

    // Sampled pins and decode
    logic [1:0]  ext_lvl;
    logic [1:0]  ext_tog;
    logic [1:0]  ext_trig;
    logic [1:0]  sense_zero;
    logic [1:0]  sense_one;
    logic [1:0]  level_mode;
    logic [23:0] pc_lvl;
    logic [23:0] pc_tog;
    logic [23:0] pc_mask_all;
    logic [2:0]  pc_hit;
    logic [1:0]  ext_wr_clr;
    logic [2:0]  pc_wr_clr;
    logic        wr_ext_flags;
    logic        wr_pc_flags;

    assign sense_zero = sense_ctl_ff[SENSE_ZERO_POS +: 2];
    assign sense_one  = sense_ctl_ff[SENSE_ONE_POS +: 2];
    assign level_mode = {sense_one == SENSE_LOW, sense_zero == SENSE_LOW};

    // pad level used regardless of direction
    pin_sync #(
        .W(2)
    ) u_ext_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_raw  ({ext_irq_pin_one, ext_irq_pin_zero}),
        .level    (ext_lvl),
        .toggled  (ext_tog)
    );

    pin_sync #(
        .W(24)
    ) u_pc_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .pin_raw  (pin_change_inputs),
        .level    (pc_lvl),
        .toggled  (pc_tog)
    );

    edge_sense u_sense_zero (
        .sense   (sense_zero),
        .level   (ext_lvl[0]),
        .toggled (ext_tog[0]),
        .run     (io_clk_run),
        .trig    (ext_trig[0])
    );

    edge_sense u_sense_one (
        .sense   (sense_one),
        .level   (ext_lvl[1]),
        .toggled (ext_tog[1]),
        .run     (io_clk_run),
        .trig    (ext_trig[1])
    );

    // masks laid over the 24 inputs, input 15 never contributes
    assign pc_mask_all = {pc_mask_two_ff, 1'b0, pc_mask_one_ff, pc_mask_zero_ff};

    // mask bit together with group enable
    always_comb
    begin
        for (int g = 0; g < 3; g++)
            pc_hit[g] = pc_enable_ff[g]
                      & (|(pc_tog[g*PC_GROUP_W +: PC_GROUP_W]
                         & pc_mask_all[g*PC_GROUP_W +: PC_GROUP_W]));
    end

    // Write-one-to-clear decode
    assign wr_ext_flags = reg_wr && (reg_addr == OFS_EXT_FLAGS);
    assign wr_pc_flags  = reg_wr && (reg_addr == OFS_PC_FLAGS);
    assign ext_wr_clr   = wr_ext_flags ? reg_wdata[1:0] : 2'h0;
    assign pc_wr_clr    = wr_pc_flags ? reg_wdata[2:0] : 3'h0;

    // Control register writes
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ext_enable_ff   <= RST_REG_ZERO[1:0];
            pc_enable_ff    <= RST_REG_ZERO[2:0];
            sense_ctl_ff    <= RST_REG_ZERO[3:0];
            pc_mask_zero_ff <= RST_REG_ZERO;
            pc_mask_one_ff  <= RST_REG_ZERO[6:0];
            pc_mask_two_ff  <= RST_REG_ZERO;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                OFS_EXT_ENABLE_MASK:  ext_enable_ff   <= reg_wdata[1:0];
                OFS_PC_GROUP_CONTROL: pc_enable_ff    <= reg_wdata[2:0];
                OFS_EXT_SENSE_CTRL:   sense_ctl_ff    <= reg_wdata[3:0];
                OFS_PC_MASK_ZERO:     pc_mask_zero_ff <= reg_wdata;
                OFS_PC_MASK_ONE:      pc_mask_one_ff  <= reg_wdata[PC_ONE_USED-1:0];
                OFS_PC_MASK_TWO:      pc_mask_two_ff  <= reg_wdata;
                default:              ;
            endcase
        end
    end

    // dedicated flags, set wins over clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ext_flag_ff <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
            begin
                if (level_mode[i])
                    ext_flag_ff[i] <= 1'b0;
                else if (ext_trig[i])
                    ext_flag_ff[i] <= 1'b1;
                else if (irq_taken[i] || ext_wr_clr[i])
                    ext_flag_ff[i] <= 1'b0;
            end
        end
    end

    // group flags, set wins over clear
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pc_flag_ff <= 3'h0;
        else
        begin
            for (int g = 0; g < 3; g++)
            begin
                if (pc_hit[g])
                    pc_flag_ff[g] <= 1'b1;
                else if (irq_taken[g+2] || pc_wr_clr[g])
                    pc_flag_ff[g] <= 1'b0;
            end
        end
    end

    // dedicated requests gated by enable and global enable
    // level mode requests while the pin stays low
    // a level gone before the clock returns raises nothing
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            ext_req_ff <= 2'h0;
        else
        begin
            for (int i = 0; i < 2; i++)
                ext_req_ff[i] <= global_irq_enable & ext_enable_ff[i]
                               & (level_mode[i] ? (~ext_lvl[i] & io_clk_run)
                                                : ext_flag_ff[i]);
        end
    end

    // group requests gated by enable and global enable
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            pc_req_ff <= 3'h0;
        else
            pc_req_ff <= pc_flag_ff & pc_enable_ff & {3{global_irq_enable}};
    end

    // low level wakes without the I/O clock
    // enabled pin changes wake as well
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            wake_ff <= 1'b0;
        else
            wake_ff <= (|pc_hit) | (|(ext_enable_ff & level_mode & ~ext_lvl));
    end

    // read mux, unused bits zero, data valid one cycle only
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= RST_REG_ZERO;
        else if (!reg_rd)
            rdata_ff <= RST_REG_ZERO;
        else
        begin
            unique case (reg_addr)
                OFS_EXT_ENABLE_MASK:  rdata_ff <= {6'h00, ext_enable_ff};
                OFS_PC_GROUP_CONTROL: rdata_ff <= {5'h00, pc_enable_ff};
                OFS_EXT_SENSE_CTRL:   rdata_ff <= {4'h0, sense_ctl_ff};
                OFS_EXT_FLAGS:        rdata_ff <= {6'h00, ext_flag_ff & ~level_mode};
                OFS_PC_FLAGS:         rdata_ff <= {5'h00, pc_flag_ff};
                OFS_PC_MASK_ZERO:     rdata_ff <= pc_mask_zero_ff;
                OFS_PC_MASK_ONE:      rdata_ff <= {1'b0, pc_mask_one_ff};
                OFS_PC_MASK_TWO:      rdata_ff <= pc_mask_two_ff;
                default:              rdata_ff <= RST_REG_ZERO;
            endcase
        end
    end

    // Outputs straight from flops
    assign reg_rdata             = rdata_ff;
    assign ext_req_zero          = ext_req_ff[0];
    assign ext_req_one           = ext_req_ff[1];
    assign pc_group_zero_request = pc_req_ff[0];
    assign pc_group_one_request  = pc_req_ff[1];
    assign pc_group_two_request  = pc_req_ff[2];
    assign wake_request          = wake_ff;

    // Checks on the logic above
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    // masked change sets the group flag
    a_pc_flag_set: assert property (pc_hit[2] |=> pc_flag_ff[2])
        else $error("group two flag not set after masked change");

    // input 15 never drives group one
    a_pc_bit_unused: assert property (
        (pc_tog[15] && !(|(pc_tog[14:8] & pc_mask_one_ff))) |-> !pc_hit[1])
        else $error("input 15 reached group one");

    // masked-off toggle does not set a flag
    a_pc_mask_off: assert property (
        (!pc_flag_ff[0] && !(|(pc_tog[7:0] & pc_mask_zero_ff))) |=> !pc_flag_ff[0])
        else $error("group zero flag set without masked change");

    // level request follows a low pin one cycle on
    a_level_req: assert property (
        (global_irq_enable && ext_enable_ff[0] && sense_zero == SENSE_LOW
         && !ext_lvl[0] && io_clk_run) |=> ext_req_zero)
        else $error("level request missing while pin low");

    // flag reads zero in level mode
    a_level_flag_zero: assert property (
        (reg_rd && reg_addr == OFS_EXT_FLAGS && level_mode[1]) |=> !reg_rdata[1])
        else $error("pin one flag read as set in level mode");

    // write one clears the flag when no edge arrives
    a_flag_w1c: assert property (
        (ext_wr_clr[0] && !ext_trig[0]) |=> !ext_flag_ff[0])
        else $error("pin zero flag survived write one");

    // no flag rise while the I/O clock is stopped
    a_edge_gated: assert property (
        (!io_clk_run && !ext_flag_ff[1]) |=> !ext_flag_ff[1])
        else $error("edge detected with I/O clock stopped");

    // rising mode flags only on a rising level
    a_rise_only: assert property (
        (ext_trig[1] && sense_one == SENSE_RISE) |-> $rose(ext_lvl[1]))
        else $error("rise mode triggered without rising level");

    a_gie_gate: assert property (
        !global_irq_enable |=> !(ext_req_zero || ext_req_one || pc_group_two_request))
        else $error("request raised with global enable clear");

    // unused bits of the enable register read zero
    a_unused_zero: assert property (
        (reg_rd && reg_addr == OFS_EXT_ENABLE_MASK) |=> reg_rdata[7:2] == 6'h00)
        else $error("unused enable bits read non-zero");

    // Main scenarios
    c_group_request: cover property (pc_hit[1] ##1 pc_flag_ff[1] ##1 pc_group_one_request);
    c_edge_request: cover property (ext_trig[0] ##1 ext_flag_ff[0] ##1 ext_req_zero);
    c_level_wake: cover property (!io_clk_run && wake_request);

endmodule

/* File: verif/board_pins.sv */
// Board-side model that drives the dedicated and pin-change pins
`timescale 1ns/1ps
module board_pins
(
    // Clock
    input  wire logic        core_clk,
    // Pins
    output logic             pin_zero,
    output logic             pin_one,
    output logic [23:0]      pc_pins
);
    // Idle pins sit high, as with pull-ups
    initial
    begin
        pin_zero = 1'b1;
        pin_one  = 1'b1;
        pc_pins  = 24'hFFFFFF;
    end

    task automatic set_ded(input int p, input logic v);
        @(posedge core_clk);
        if (p == 0)
            pin_zero <= v;
        else
            pin_one <= v;
        repeat (10) @(posedge core_clk);
    endtask

    task automatic flip_pc(input int i);
        @(posedge core_clk);
        pc_pins[i] <= ~pc_pins[i];
        repeat (10) @(posedge core_clk);
    endtask
endmodule

/* File: verif/external_pin_interrupt_unit_bench.sv */
// Self-checking bench for the external pin interrupt unit
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    begin \
        num_checks++; \
        if ((got) !== (exp)) \
        begin \
            $display("BAD %s exp %0h got %0h", what, exp, got); \
            num_errors++; \
        end \
    end
module external_pin_interrupt_unit_bench
    import ext_irq_pkg::*;
;
    logic              core_clk;
    logic              rstn;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              gie;
    logic              io_run;
    logic [4:0]        irq_taken;
    logic              pin_zero;
    logic              pin_one;
    logic [23:0]       pc_pins;
    logic              req_zero;
    logic              req_one;
    logic [2:0]        grp_req;
    logic              wake;
    logic [7:0]        rd_val;
    int                num_errors;
    int                num_checks;

    // Register map and values read back after writing all ones
    localparam logic [7:0] MAP [8] = '{OFS_EXT_ENABLE_MASK, OFS_PC_GROUP_CONTROL,
        OFS_PC_MASK_ZERO, OFS_PC_MASK_ONE, OFS_PC_MASK_TWO, OFS_EXT_SENSE_CTRL,
        OFS_EXT_FLAGS, OFS_PC_FLAGS};
    localparam logic [7:0] ONES [8] = '{8'h03, 8'h07, 8'hFF, 8'h7F, 8'hFF, 8'h0F,
        8'h00, 8'h00};

    external_pin_interrupt_unit dut_u (
        .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .global_irq_enable(gie), .io_clk_run(io_run),
        .irq_taken(irq_taken), .ext_irq_pin_zero(pin_zero),
        .ext_irq_pin_one(pin_one), .pin_change_inputs(pc_pins),
        .ext_req_zero(req_zero), .ext_req_one(req_one),
        .pc_group_zero_request(grp_req[0]), .pc_group_one_request(grp_req[1]),
        .pc_group_two_request(grp_req[2]), .wake_request(wake));

    board_pins board_u (.core_clk(core_clk), .pin_zero(pin_zero),
        .pin_one(pin_one), .pc_pins(pc_pins));

    // Clock at 4 ns period
    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // One-cycle write strobe
    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic reg_read(input logic [7:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask

    // Let outputs settle after a number of edges
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    // Handler entry pulse
    task automatic take(input logic [4:0] v);
        @(posedge core_clk);
        irq_taken <= v;
        @(posedge core_clk);
        irq_taken <= 5'h00;
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Cut a hang short
    initial
    begin
        repeat (50000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        num_errors = 0;
        num_checks = 0;
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        gie = 1'b1;
        io_run = 1'b1;
        irq_taken = 5'h00;
        repeat (12) @(posedge core_clk);
        rstn <= 1'b1;
        // Reset values, unused bits and unmapped place
        for (int i = 0; i < 8; i++)
        begin
            reg_read(MAP[i]);
            `CHK("reset", 8'h00, rd_val);
            reg_write(MAP[i], 8'hFF);
            reg_read(MAP[i]);
            `CHK("ones", ONES[i], rd_val);
            reg_write(MAP[i], 8'h00);
        end
        reg_read(8'h55);
        `CHK("unmapped", 8'h00, rd_val);
        // Edge and change modes on both dedicated pins
        for (int p = 0; p < 2; p++)
        begin
            for (int m = 1; m < 4; m++)
            begin
                reg_write(OFS_EXT_SENSE_CTRL, 8'(m << (2 * p)));
                reg_write(OFS_EXT_FLAGS, 8'h03);
                board_u.set_ded(p, 1'b0);
                reg_read(OFS_EXT_FLAGS);
                `CHK("fall", 8'((m != 3) << p), rd_val);
                reg_write(OFS_EXT_FLAGS, 8'h03);
                board_u.set_ded(p, 1'b1);
                reg_read(OFS_EXT_FLAGS);
                `CHK("rise", 8'((m != 2) << p), rd_val);
            end
        end
        // Level mode on pin zero
        reg_write(OFS_EXT_FLAGS, 8'h03);
        reg_write(OFS_EXT_SENSE_CTRL, 8'h00);
        reg_write(OFS_EXT_ENABLE_MASK, 8'h01);
        board_u.set_ded(0, 1'b0);
        reg_read(OFS_EXT_FLAGS);
        `CHK("lvl flag", 8'h00, rd_val);
        settle(1);
        `CHK("lvl req", 1'b1, req_zero);
        gie <= 1'b0;
        settle(3);
        `CHK("gie off", 1'b0, req_zero);
        gie <= 1'b1;
        io_run <= 1'b0;
        settle(3);
        `CHK("sleep req", 1'b0, req_zero);
        `CHK("sleep wake", 1'b1, wake);
        io_run <= 1'b1;
        board_u.set_ded(0, 1'b1);
        settle(1);
        `CHK("lvl gone", 1'b0, req_zero);
        `CHK("wake gone", 1'b0, wake);
        // Rising edge request, cleared by handler entry
        reg_write(OFS_EXT_SENSE_CTRL, 8'h0F);
        reg_write(OFS_EXT_ENABLE_MASK, 8'h02);
        board_u.set_ded(1, 1'b0);
        board_u.set_ded(1, 1'b1);
        settle(1);
        `CHK("edge req", 2'b10, {req_one, req_zero});
        take(5'h02);
        settle(3);
        `CHK("taken", 1'b0, req_one);
        // Edges ignored while the I/O clock is stopped
        io_run <= 1'b0;
        board_u.set_ded(0, 1'b0);
        board_u.set_ded(0, 1'b1);
        reg_read(OFS_EXT_FLAGS);
        `CHK("no clk", 8'h00, rd_val);
        // Pin-change groups, detected with the I/O clock stopped
        reg_write(OFS_PC_GROUP_CONTROL, 8'h07);
        for (int g = 0; g < 3; g++)
        begin
            reg_write(OFS_PC_MASK_ZERO + 8'(g), 8'h01);
            board_u.flip_pc(8 * g + 1);
            reg_read(OFS_PC_FLAGS);
            `CHK("masked", 8'h00, rd_val);
            board_u.flip_pc(8 * g);
            reg_read(OFS_PC_FLAGS);
            `CHK("grp flag", 8'(1 << g), rd_val);
            `CHK("grp req", 3'(1 << g), grp_req);
            reg_write(OFS_PC_FLAGS, 8'(1 << g));
            reg_read(OFS_PC_FLAGS);
            `CHK("grp clr", 8'h00, rd_val);
            board_u.flip_pc(8 * g);
            take(5'(4 << g));
            reg_read(OFS_PC_FLAGS);
            `CHK("grp taken", 8'h00, rd_val);
        end
        io_run <= 1'b1;
        reg_write(OFS_PC_MASK_ONE, 8'hFF);
        board_u.flip_pc(15);
        reg_read(OFS_PC_FLAGS);
        `CHK("bit15", 8'h00, rd_val);
        reg_write(OFS_PC_GROUP_CONTROL, 8'h00);
        board_u.flip_pc(0);
        reg_read(OFS_PC_FLAGS);
        `CHK("grp off", 8'h00, rd_val);
        wrap_up();
    end
endmodule
